// >>> core/mic_pkg.sv
`default_nettype none
package mic_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_STATUS_FIRST = 8'h06;
	localparam logic [7:0] IDX_ENABLE_FIRST = 8'h07;
	localparam logic [7:0] IDX_STATUS_SECOND = 8'h08;
	localparam logic [7:0] IDX_ENABLE_SECOND = 8'h09;
	localparam logic [7:0] IDX_CONTROL = 8'h0A;
	localparam logic [7:0] IDX_CORE_STATE = 8'h0B;
	// implemented bit masks
	localparam logic [7:0] MASK_FIRST = 8'h1F;
	localparam logic [7:0] MASK_SECOND = 8'h7F;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// bit positions
	localparam int BIT_PROG_MEM = 4;
	localparam int BIT_DATA_MEM = 3;
	localparam int BIT_PORT_A = 2;
	localparam int BIT_TRAP = 1;
	localparam int BIT_STACK = 0;
	localparam int BIT_WATCHDOG = 6;
	localparam int BIT_FUEL = 5;
	localparam int BIT_POWER_FAIL = 4;
	localparam int BIT_CONVERSION = 3;
	localparam int BIT_OVERCURRENT = 2;
	localparam int BIT_SMBUS = 1;
	localparam int BIT_TIMER = 0;
	localparam int BIT_GIE = 0;
	// vector and stack
	localparam logic [12:0] VECTOR_ADDR = 13'h17FE;
	localparam logic [3:0] STACK_DEPTH = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> core/mic_edge_sync.sv
`default_nettype none
// three-stage synchroniser with agreement check and rising-edge pulse
module mic_edge_sync (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// raw asynchronous level
	input wire logic async_in,
	// synchronised level and its rising edge
	output logic level_out,
	output logic rise_out
);
	logic s1_ff, s2_ff, s3_ff, lvl_ff;

	// first stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// level changes only when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			lvl_ff <= s3_ff;
		end
	end

	assign level_out = lvl_ff;
	assign rise_out = (s2_ff == s3_ff) && s3_ff && !lvl_ff;
endmodule // mic_edge_sync
`default_nettype wire

// >>> core/mic_irq_ctrl.sv
// Function
// - enable bit one permits its source, zero blocks it
// - any enabled event wakes the sleeping core; disabled ones do not
// - status flags set on source events regardless of enable bits
// - flag, enable and global enable all set vectors core to 0x17FE
// - entry saves program counter and carry, digit-carry, zero in hidden shadow
// - working accumulator is not saved on interrupt entry
// - return-from-interrupt restores program counter and flags from shadow
// - first enable D4 gates program memory done (both enables back high)
// - first enable D3 gates data memory write or clear done
// - first enable D2 gates port A, qualified by pin 3/4 enables
// - first enable D1 gates the software trap instruction event
// - first enable D0 gates stack fault: call when full, return when empty
// - second D6 enables watchdog irq; debug bit blocks watchdog reset
// - second D4 enables power-fail, held while analog supply below 3.0V
// - second enable: fuel D5, conversion D3, overcurrent D2, SMBus D1
// - second D0 enables periodic timer tick from slow oscillator
// - unused enable bits read zero; all enables zero after reset
// - flags caught the cycle after the event; writing one leaves flag unchanged
// - power-fail is level-sensitive; others edge-triggered, rearm after clear
// - first status: prog D4, data D3, port A D2, trap D1, stack D0
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module mic_irq_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// memory controller chip and output enables, active low, same clock
	input wire logic mem_chip_enable_n,
	input wire logic mem_output_enable_n,
	input wire logic mem_target_data,
	// port A pin and its configuration, pins 3 and 4
	input wire logic [1:0] port_a_pin,
	input wire logic [1:0] port_a_pin_irq_enable,
	input wire logic [1:0] port_a_pin_enable,
	// core-side event pulses, same clock
	input wire logic trap_exec,
	input wire logic call_exec,
	input wire logic return_exec,
	input wire logic return_from_interrupt_instr,
	input wire logic [3:0] stack_level,
	// peripheral event pulses, same clock
	input wire logic watchdog_expire,
	input wire logic fuel_gauge_event,
	input wire logic conversion_done,
	input wire logic overcurrent_event,
	input wire logic smbus_event,
	input wire logic timer_tick,
	// analog comparator, high while supply is below threshold
	input wire logic analog_supply_low,
	// debug configuration
	input wire logic debug_enable_bit,
	// core state for save and restore
	input wire logic [12:0] core_pc,
	input wire logic core_carry,
	input wire logic core_digit_carry,
	input wire logic core_zero,
	input wire logic core_sleeping,
	// to the program sequencer
	output logic irq_take,
	output logic [12:0] irq_vector,
	output logic restore_valid,
	output logic [12:0] restore_pc,
	output logic [2:0] restore_flags,
	output logic wake,
	output logic irq_pending,
	output logic watchdog_reset
);
	// -----------------------------------------------------------------
	// registers and wires
	// -----------------------------------------------------------------
	logic [7:0] enable_first_ff, enable_second_ff;
	logic [7:0] status_first_ff, status_second_ff;
	logic gie_ff;
	logic in_service_ff;
	logic [12:0] shadow_pc_ff;
	logic [2:0] shadow_flags_ff;
	logic mem_done_prev_ff;
	logic [7:0] event_first, event_second;
	logic [7:0] pend_first, pend_second;
	logic any_pending;
	logic [1:0] pin_level, pin_rise;
	logic pf_level, pf_rise;
	logic mem_done;
	logic [7:0] clr_first, clr_second;
	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// port A pins and the supply comparator come from outside the clock
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			mic_edge_sync u_pin_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.async_in(port_a_pin[gi]),
				.level_out(pin_level[gi]),
				.rise_out(pin_rise[gi])
			);
		end
	endgenerate

	mic_edge_sync u_pf_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(analog_supply_low),
		.level_out(pf_level),
		.rise_out(pf_rise)
	);
	// -----------------------------------------------------------------
	// event detection
	// -----------------------------------------------------------------
	// memory op done when both enables return high
	assign mem_done = mem_chip_enable_n && mem_output_enable_n;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_done_prev_ff <= 1'b1;
		end else begin
			mem_done_prev_ff <= mem_done;
		end
	end

	// one event vector per status register
	always_comb begin
		event_first = 8'h00;
		event_second = 8'h00;
		event_first[mic_pkg::BIT_PROG_MEM] = mem_done && !mem_done_prev_ff
			&& !mem_target_data;
		event_first[mic_pkg::BIT_DATA_MEM] = mem_done && !mem_done_prev_ff
			&& mem_target_data;
		event_first[mic_pkg::BIT_PORT_A] = |(pin_rise & port_a_pin_irq_enable
			& port_a_pin_enable);
		event_first[mic_pkg::BIT_TRAP] = trap_exec;
		event_first[mic_pkg::BIT_STACK] = (call_exec && stack_level == mic_pkg::STACK_DEPTH)
			|| (return_exec && stack_level == 4'h0);
		event_second[mic_pkg::BIT_WATCHDOG] = watchdog_expire && debug_enable_bit;
		event_second[mic_pkg::BIT_FUEL] = fuel_gauge_event;
		// level source: re-set every cycle the supply stays low
		event_second[mic_pkg::BIT_POWER_FAIL] = pf_level || pf_rise;
		event_second[mic_pkg::BIT_CONVERSION] = conversion_done;
		event_second[mic_pkg::BIT_OVERCURRENT] = overcurrent_event;
		event_second[mic_pkg::BIT_SMBUS] = smbus_event;
		event_second[mic_pkg::BIT_TIMER] = timer_tick;
	end
	// -----------------------------------------------------------------
	// axi4-lite slave
	// -----------------------------------------------------------------
	logic aw_held_ff, w_held_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;
	logic [9:0] wr_idx;
	assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wr_idx = awaddr_ff[11:2];
	// address and data taken in either order, one write in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= mic_pkg::RESP_OKAY;
			s_axi_awready <= 1'b1; // ready may stand high in reset; valids may not
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_idx[9:8] == 2'h0 && wr_idx[7:0] >= mic_pkg::IDX_STATUS_FIRST
					&& wr_idx[7:0] <= mic_pkg::IDX_CONTROL) ? mic_pkg::RESP_OKAY
					: mic_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read path answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= mic_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= mic_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr[11:10] != 2'h0) begin
				s_axi_rresp <= mic_pkg::RESP_SLVERR;
			end else begin
				case (s_axi_araddr[9:2])
					mic_pkg::IDX_STATUS_FIRST: s_axi_rdata[7:0] <= status_first_ff;
					mic_pkg::IDX_ENABLE_FIRST: s_axi_rdata[7:0] <= enable_first_ff;
					mic_pkg::IDX_STATUS_SECOND: s_axi_rdata[7:0] <= status_second_ff;
					mic_pkg::IDX_ENABLE_SECOND: s_axi_rdata[7:0] <= enable_second_ff;
					mic_pkg::IDX_CONTROL: s_axi_rdata[0] <= gie_ff;
					mic_pkg::IDX_CORE_STATE: s_axi_rdata[1:0] <= {in_service_ff, any_pending};
					default: s_axi_rresp <= mic_pkg::RESP_SLVERR;
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// enable registers
	// -----------------------------------------------------------------
	// unused bits masked so they always read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_first_ff <= mic_pkg::ENABLE_RESET;
			enable_second_ff <= mic_pkg::ENABLE_RESET;
		end else if (do_write && wstrb_ff[0] && wr_idx[9:8] == 2'h0) begin
			if (wr_idx[7:0] == mic_pkg::IDX_ENABLE_FIRST) begin
				enable_first_ff <= wdata_ff[7:0] & mic_pkg::MASK_FIRST;
			end
			if (wr_idx[7:0] == mic_pkg::IDX_ENABLE_SECOND) begin
				enable_second_ff <= wdata_ff[7:0] & mic_pkg::MASK_SECOND;
			end
		end
	end

	// -----------------------------------------------------------------
	// status flags
	// -----------------------------------------------------------------
	// only a zero clears a flag; writing one has no effect
	always_comb begin
		clr_first = 8'h00;
		clr_second = 8'h00;
		if (do_write && wstrb_ff[0] && wr_idx[9:8] == 2'h0) begin
			if (wr_idx[7:0] == mic_pkg::IDX_STATUS_FIRST) begin
				clr_first = ~wdata_ff[7:0];
			end
			if (wr_idx[7:0] == mic_pkg::IDX_STATUS_SECOND) begin
				clr_second = ~wdata_ff[7:0];
			end
		end
	end
	// registered next cycle after the event; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_first_ff <= mic_pkg::STATUS_RESET;
			status_second_ff <= mic_pkg::STATUS_RESET;
		end else begin
			status_first_ff <= ((status_first_ff & ~clr_first) | event_first)
				& mic_pkg::MASK_FIRST;
			status_second_ff <= ((status_second_ff & ~clr_second) | event_second)
				& mic_pkg::MASK_SECOND;
		end
	end

	// -----------------------------------------------------------------
	// global enable and request
	// -----------------------------------------------------------------
	assign pend_first = status_first_ff & enable_first_ff;
	assign pend_second = status_second_ff & enable_second_ff;
	assign any_pending = |{pend_first, pend_second};
	// taking an interrupt clears the global enable; return sets it again
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gie_ff <= 1'b0;
		end else if (irq_take) begin
			gie_ff <= 1'b0;
		end else if (return_from_interrupt_instr && in_service_ff) begin
			gie_ff <= 1'b1;
		end else if (do_write && wstrb_ff[0] && wr_idx == {2'h0, mic_pkg::IDX_CONTROL}) begin
			gie_ff <= wdata_ff[mic_pkg::BIT_GIE];
		end
	end

	// -----------------------------------------------------------------
	// sequencer handshake and shadow store
	// -----------------------------------------------------------------
	// edge-triggered at the core: one call per service, none again until return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_take <= 1'b0;
			irq_vector <= 13'h0000;
			in_service_ff <= 1'b0;
			shadow_pc_ff <= 13'h0000;
			shadow_flags_ff <= 3'h0;
		end else begin
			irq_take <= 1'b0;
			if (any_pending && gie_ff && !in_service_ff && !irq_take) begin
				irq_take <= 1'b1;
				irq_vector <= mic_pkg::VECTOR_ADDR;
				in_service_ff <= 1'b1;
				// accumulator is deliberately absent from the shadow
				shadow_pc_ff <= core_pc;
				shadow_flags_ff <= {core_carry, core_digit_carry, core_zero};
			end else if (return_from_interrupt_instr && in_service_ff) begin
				in_service_ff <= 1'b0;
			end
		end
	end
	// restore pulses one cycle after the return instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restore_valid <= 1'b0;
			restore_pc <= 13'h0000;
			restore_flags <= 3'h0;
		end else begin
			restore_valid <= return_from_interrupt_instr && in_service_ff;
			if (return_from_interrupt_instr && in_service_ff) begin
				restore_pc <= shadow_pc_ff;
				restore_flags <= shadow_flags_ff;
			end
		end
	end

	// -----------------------------------------------------------------
	// wake, pending and watchdog reset
	// -----------------------------------------------------------------
	// wake ignores the global enable so a sleeping core always rises
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake <= 1'b0;
			irq_pending <= 1'b0;
			watchdog_reset <= 1'b0;
		end else begin
			wake <= core_sleeping && any_pending;
			irq_pending <= any_pending && gie_ff;
			watchdog_reset <= watchdog_expire && !debug_enable_bit;
		end
	end
endmodule // mic_irq_ctrl
`default_nettype wire

// >>> verif/mic_irq_props.sv
`default_nettype none
module mic_irq_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core side inputs
	input wire logic return_from_interrupt_instr,
	input wire logic watchdog_expire,
	input wire logic debug_enable_bit,
	input wire logic [12:0] core_pc,
	input wire logic core_carry,
	input wire logic core_digit_carry,
	input wire logic core_zero,
	input wire logic core_sleeping,
	// sequencer side outputs
	input wire logic irq_take,
	input wire logic [12:0] irq_vector,
	input wire logic restore_valid,
	input wire logic [12:0] restore_pc,
	input wire logic [2:0] restore_flags,
	input wire logic wake,
	input wire logic watchdog_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic svc_ff;
	logic [15:0] saved_ff;
	// own copy of the saved state, so a wrong shadow cannot hide
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			svc_ff <= 1'h0;
			saved_ff <= 16'h0000;
		end else if (irq_take) begin
			svc_ff <= 1'h1;
			saved_ff <= {core_carry, core_digit_carry, core_zero, core_pc};
		end else if (restore_valid) begin
			svc_ff <= 1'h0;
		end
	end
	// return while in service, then a single restore pulse
	sequence s_ret;
		return_from_interrupt_instr && svc_ff;
	endsequence
	sequence s_back;
		restore_valid ##1 !restore_valid;
	endsequence
	a_take_vector: assert property (irq_take |=> irq_vector == 13'h17FE)
		else $error("call taken without the fixed vector");
	a_take_pulse: assert property (irq_take |=> !irq_take)
		else $error("call request longer than one cycle");
	a_no_retake: assert property (irq_take |-> !svc_ff)
		else $error("second call before return");
	a_restore_state: assert property (restore_valid |-> {restore_flags, restore_pc} == saved_ff)
		else $error("restored state differs from saved state");
	a_restore_cause: assert property (s_ret |=> s_back)
		else $error("return not followed by one restore pulse");
	a_wake_sleep: assert property (wake |-> $past(core_sleeping))
		else $error("wake while core was running");
	a_wdog_reset: assert property (watchdog_reset |-> $past(watchdog_expire) && !$past(debug_enable_bit))
		else $error("watchdog reset without expiry or in debug");
	a_reset_quiet: assert property ($rose(aresetn) |-> !irq_take && !restore_valid)
		else $error("sequencer request right after reset");
endmodule // mic_irq_props
bind mic_irq_ctrl mic_irq_props mic_irq_props_inst (.aclk, .aresetn,
	.return_from_interrupt_instr, .watchdog_expire, .debug_enable_bit, .core_pc, .core_carry,
	.core_digit_carry, .core_zero, .core_sleeping, .irq_take, .irq_vector, .restore_valid,
	.restore_pc, .restore_flags, .wake, .watchdog_reset);
`default_nettype wire

// >>> verif/mic_core_model.sv
`default_nettype none
module mic_core_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control: state load and sleep request
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic go_sleep,
	// from the controller
	input wire logic irq_take,
	input wire logic [12:0] irq_vector,
	input wire logic restore_valid,
	input wire logic [12:0] restore_pc,
	input wire logic [2:0] restore_flags,
	input wire logic wake,
	// to the controller
	output logic [12:0] core_pc,
	output logic core_carry,
	output logic core_digit_carry,
	output logic core_zero,
	output logic core_sleeping
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] state_ff;
	logic sleep_ff;
	// flags, then program counter; the routine clobbers the flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= 16'h0000;
		end else if (load) begin
			state_ff <= load_val;
		end else if (irq_take) begin
			state_ff <= {3'h2, irq_vector};
		end else if (restore_valid) begin
			state_ff <= {restore_flags, restore_pc};
		end
	end
	// sleeps on request until the controller wakes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_ff <= 1'h0;
		end else if (wake) begin
			sleep_ff <= 1'h0;
		end else if (go_sleep) begin
			sleep_ff <= 1'h1;
		end
	end
	// outputs straight from state
	assign {core_carry, core_digit_carry, core_zero, core_pc} = state_ff;
	assign core_sleeping = sleep_ff;
endmodule // mic_core_model
`default_nettype wire

// >>> verif/tb_mic_irq_ctrl.sv
`default_nettype none
module tb_mic_irq_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus, all but the address a given a value at time zero
	logic aclk = 1'h0, aresetn = 1'h0, load = 1'h0, go_sleep = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, a;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF, stack_level = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, mem_target_data = 1'h0;
	logic mem_chip_enable_n = 1'h1, mem_output_enable_n = 1'h1;
	logic [1:0] port_a_pin = 2'h0, port_a_pin_irq_enable = 2'h3, port_a_pin_enable = 2'h3;
	logic trap_exec = 1'h0, call_exec = 1'h0, return_exec = 1'h0;
	logic return_from_interrupt_instr = 1'h0, watchdog_expire = 1'h0, fuel_gauge_event = 1'h0;
	logic conversion_done = 1'h0, overcurrent_event = 1'h0, smbus_event = 1'h0;
	logic timer_tick = 1'h0, analog_supply_low = 1'h0, debug_enable_bit = 1'h0;
	logic [15:0] load_val = 16'hAABC;
	// design outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata;
	logic [12:0] core_pc, irq_vector, restore_pc;
	logic [2:0] restore_flags;
	logic core_carry, core_digit_carry, core_zero, core_sleeping, irq_take, restore_valid;
	logic wake, irq_pending, watchdog_reset;
	int mismatches = 0, n_compared = 0, cycles = 0, n_take = 0, n_wdr = 0, k;
	int bp [12] = '{4, 3, 2, 1, 0, 0, 6, 5, 3, 2, 1, 0};
	mic_irq_ctrl mic_irq_ctrl_inst (.*);
	mic_core_model mic_core_model_inst (.*);
	always #4 aclk = ~aclk;
	// event counters and the hang limit
	always @(posedge aclk) begin
		cycles++;
		n_take += (irq_take === 1'h1);
		n_wdr += (watchdog_reset === 1'h1);
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// handshakes are judged 1 ns after an edge, when ready has settled
	task wr(input logic [11:0] ad, input logic [7:0] v);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			#1;
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
		end while (b !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask
	task rchk(input logic [11:0] ad, input logic [31:0] exp);
		logic ar, rv;
		logic [31:0] v;
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			#1;
			ar = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			v = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'h0;
		end while (rv !== 1'h1);
		s_axi_rready <= 1'h0;
		chk(v, exp);
	endtask
	// one source event by index; pin held long enough for its synchroniser
	task ev(input int n);
		@(posedge aclk);
		mem_target_data <= (n == 1);
		stack_level <= (n == 4) ? 4'h8 : 4'h0;
		{mem_chip_enable_n, mem_output_enable_n} <= {2{n > 1}};
		port_a_pin <= 2'(n == 2);
		{go_sleep, return_from_interrupt_instr, timer_tick, smbus_event, overcurrent_event,
			conversion_done, fuel_gauge_event, watchdog_expire, return_exec, call_exec,
			trap_exec} <= 11'((14'h1 << n) >> 3);
		@(posedge aclk);
		{mem_chip_enable_n, mem_output_enable_n} <= 2'h3;
		{go_sleep, return_from_interrupt_instr, timer_tick, smbus_event, overcurrent_event,
			conversion_done, fuel_gauge_event, watchdog_expire, return_exec, call_exec,
			trap_exec} <= 11'h000;
		repeat (6) @(posedge aclk);
		port_a_pin <= 2'h0;
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		// reset state, implemented bits, unmapped address
		for (k = 0; k < 4; k++) rchk(12'h018 + 12'(4 * k), 32'h0);
		wr(12'h01C, 8'hFF);
		rchk(12'h01C, 32'h1F);
		chk(32'(resp), 32'h0);
		wr(12'h024, 8'hFF);
		rchk(12'h024, 32'h7F);
		wr(12'h03C, 8'hFF);
		chk(32'(resp), 32'h2);
		rchk(12'h03C, 32'h0);
		chk(32'(resp), 32'h2);
		wr(12'h01C, 8'h00);
		wr(12'h024, 8'h00);
		// every source but power-fail flags with enables clear; ones keep, zeros clear
		debug_enable_bit <= 1'h1;
		for (k = 0; k < 12; k++) begin
			a = (k < 6) ? 12'h018 : 12'h020;
			ev(k);
			rchk(a, 32'h1 << bp[k]);
			wr(a, 8'hFF);
			rchk(a, 32'h1 << bp[k]);
			wr(a, 8'h00);
			rchk(a, 32'h0);
		end
		// without debug the watchdog resets instead of flagging
		debug_enable_bit <= 1'h0;
		ev(6);
		chk(32'(n_wdr), 32'h1);
		rchk(12'h020, 32'h0);
		// low supply keeps re-setting its flag while it lasts
		analog_supply_low <= 1'h1;
		repeat (8) @(posedge aclk);
		wr(12'h020, 8'h00);
		rchk(12'h020, 32'h10);
		analog_supply_low <= 1'h0;
		repeat (8) @(posedge aclk);
		wr(12'h020, 8'h00);
		rchk(12'h020, 32'h0);
		// only an enabled source wakes the sleeping core
		ev(13);
		ev(3);
		chk(32'(core_sleeping), 32'h1);
		wr(12'h018, 8'h00);
		wr(12'h01C, 8'h02);
		ev(3);
		chk(32'(core_sleeping), 32'h0);
		chk(32'(n_take), 32'h0);
		// global enable starts the call; return brings the state back
		load <= 1'h1;
		@(posedge aclk);
		load <= 1'h0;
		wr(12'h028, 8'h01);
		repeat (4) @(posedge aclk);
		chk(32'(n_take), 32'h1);
		chk(32'(core_pc), 32'h17FE);
		chk(32'(irq_pending), 32'h0);
		rchk(12'h02C, 32'h3);
		wr(12'h018, 8'h00);
		ev(12);
		chk(32'(core_pc), 32'h0ABC);
		chk(32'({core_carry, core_digit_carry, core_zero}), 32'h5);
		chk(32'(n_take), 32'h1);
		final_report();
	end
endmodule // tb_mic_irq_ctrl
`default_nettype wire
